// ===== rtl/clfp_ctrl.sv
/*
  Line fill and dirty-line push controller for an instruction and a data cache.
  Assumes a synchronous processor bus slave answering with ack, error ack,
  burst inhibit and fill cache inhibit; tag arrays live outside and are steered here.
*/
`timescale 1ns/1ps
`default_nettype none

module clfp_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  // Cache access counting
  input wire logic IC_HALF_ACCESS,
  input wire logic DC_READ_HALF,
  input wire logic DC_CB_WRITE_LINE,
  input wire logic DC_WT_TRANSFER,
  // Miss request
  input wire logic MISS_REQ,
  input wire logic MISS_IS_DATA,
  input wire logic MISS_IS_WRITE_CB,
  input wire logic MISS_AWAIT2,
  input wire logic [31:0] MISS_ADDR,
  input wire logic [3:0] SET_VALID,
  input wire logic [3:0] VICTIM_DIRTY,
  input wire logic [127:0] VICTIM_LINE,
  input wire logic [31:0] VICTIM_ADDR,
  // Explicit push or noncachable hit
  input wire logic PUSH_REQ,
  input wire logic PUSH_LOCKED,
  output logic MISS_READY,
  // Cache array steering
  output logic [1:0] FILL_WAY,
  output logic VICTIM_INVALIDATE,
  output logic VICTIM_RESTORE,
  output logic LINE_WRITE,
  output logic [127:0] LINE_BUF,
  output logic [3:0] LINE_BUF_VALID,
  output logic SNOOP_PUSH_VALID,
  output logic WRITE_THROUGH,
  // Forwarded data
  output logic FWD_VALID,
  input wire logic FWD_READY,
  output logic [31:0] FWD_DATA,
  // Exceptions
  output logic BERR_NOW,
  output logic BERR_PENDING,
  // Processor bus
  output logic BUS_REQ,
  output logic [31:0] BUS_ADDR,
  output logic [1:0] TRANSFER_SIZE_CODE,
  output logic [1:0] FILL_WAY_INDEX,
  output logic [2:0] TRANSFER_MODIFIER,
  output logic BUS_WRITE,
  output logic BUS_LOCK,
  output logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic TRANSFER_ACK,
  input wire logic TRANSFER_ERROR_ACK,
  input wire logic BURST_INHIBIT,
  input wire logic FILL_CACHE_INHIBIT
);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  // ---------------------------------------------------------------
  // Replacement
  // ---------------------------------------------------------------
  logic [1:0] ic_way;
  logic [1:0] dc_way;
  wire take_i = MISS_REQ && MISS_READY && !MISS_IS_DATA;
  wire take_d = MISS_REQ && MISS_READY && MISS_IS_DATA;
  wire dc_adv = DC_READ_HALF || DC_CB_WRITE_LINE || DC_WT_TRANSFER;

  clfp_victim u_ic (
    .clk(MCLK), .rst(RST), .way_valid(SET_VALID),
    .adv(IC_HALF_ACCESS), .take(take_i), .way(ic_way), .cnt()
  );
  clfp_victim u_dc (
    .clk(MCLK), .rst(RST), .way_valid(SET_VALID),
    .adv(dc_adv), .take(take_d), .way(dc_way), .cnt()
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  clfp_pkg::clfp_state_t state_r;
  clfp_pkg::clfp_state_t state_nxt;
  logic [1:0] beat_r;
  logic [1:0] first_idx_r;
  logic [31:0] line_addr_r;
  logic is_data_r;
  logic cb_write_r;
  logic await2_r;
  logic inhibit_r;
  logic burst_off_r;
  logic [1:0] way_r;
  logic push_line_r;
  logic pb_valid_r;
  logic [127:0] pb_line_r;
  logic [31:0] pb_addr_r;
  logic [3:0] pb_dirty_r;
  logic restore_r;
  logic line_write_r;
  logic wthr_r;
  logic inval_r;
  logic berr_now_r;
  logic berr_pend_r;
  logic req_r;
  logic write_r;
  logic lock_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [1:0] size_r;
  logic [2:0] tm_r;
  logic [127:0] lbuf_r;
  logic [3:0] lbuf_v_r;
  logic fifo_in_ready;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] first_one(input logic [3:0] v);
    first_one = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : first_one

  function automatic logic many_dirty(input logic [3:0] v);
    many_dirty = (v & (v - 4'h1)) != 4'h0;
  endfunction : many_dirty

  function automatic logic [31:0] word_of(input logic [127:0] line, input logic [1:0] idx);
    word_of = line[{idx, 5'h00} +: clfp_pkg::WORD_W];
  endfunction : word_of

  function automatic logic [1:0] push_start(input logic [3:0] v);
    push_start = many_dirty(v) ? 2'h0 : first_one(v);
  endfunction : push_start

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire idle = state_r == clfp_pkg::CLFP_IDLE;
  wire in_fill = state_r == clfp_pkg::CLFP_FILL;
  wire in_push = state_r == clfp_pkg::CLFP_PUSH;
  wire in_done = state_r == clfp_pkg::CLFP_DONE;
  wire in_wthr = state_r == clfp_pkg::CLFP_WTHR;
  wire in_xfer = in_fill || in_push;
  wire ack_seen = in_xfer && req_r && TRANSFER_ACK && !TRANSFER_ERROR_ACK;
  wire both_seen = in_xfer && req_r && TRANSFER_ACK && TRANSFER_ERROR_ACK;
  wire err_seen = in_xfer && req_r && !TRANSFER_ACK && TRANSFER_ERROR_ACK;
  wire first_beat = beat_r == 2'h0;
  wire last_beat = beat_r == clfp_pkg::IDX_LAST;
  wire retry_now = both_seen && first_beat;
  wire fault_now = err_seen || (both_seen && !first_beat);
  wire pseudo_mode = first_beat ? BURST_INHIBIT : burst_off_r;
  wire single_push = in_push && !push_line_r;
  wire xfer_end = fault_now || (ack_seen && (last_beat || single_push));
  wire gap_now = ack_seen && pseudo_mode && !xfer_end;
  wire accept_miss = idle && MISS_REQ;
  wire accept_push = idle && !MISS_REQ && PUSH_REQ && (|VICTIM_DIRTY);
  wire push_after_fill = in_done && !wthr_r && pb_valid_r && line_write_r;
  wire start_push = accept_push || push_after_fill;
  wire [1:0] pick_way = MISS_IS_DATA ? dc_way : ic_way;
  wire [1:0] word_idx = first_idx_r + beat_r;
  wire [1:0] next_idx = word_idx + 2'h1;
  wire [1:0] beat_next = beat_r + 2'h1;
  wire fill_last = in_fill && ack_seen && last_beat;
  wire await_hit = await2_r && beat_r == 2'h1;
  wire fwd_push = in_fill && ack_seen;
  wire [127:0] src_line = idle ? VICTIM_LINE : pb_line_r;
  wire [3:0] src_dirty = idle ? VICTIM_DIRTY : pb_dirty_r;
  wire [31:0] src_addr = idle ? VICTIM_ADDR : pb_addr_r;
  wire [1:0] src_idx = push_start(src_dirty);
  wire [31:0] fill_gap_addr = {line_addr_r[31:4], next_idx, 2'h0};
  wire [31:0] push_gap_addr = {pb_addr_r[31:4], beat_next, 2'h0};
  wire [31:0] gap_addr = in_push ? push_gap_addr : fill_gap_addr;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      clfp_pkg::CLFP_IDLE: begin
        if (accept_miss) state_nxt = clfp_pkg::CLFP_FILL;
        else if (accept_push) state_nxt = clfp_pkg::CLFP_PUSH;
      end
      clfp_pkg::CLFP_FILL: begin
        if (xfer_end) state_nxt = clfp_pkg::CLFP_DONE;
      end
      clfp_pkg::CLFP_DONE: begin
        if (wthr_r) state_nxt = clfp_pkg::CLFP_WTHR;
        else if (push_after_fill) state_nxt = clfp_pkg::CLFP_PUSH;
        else state_nxt = clfp_pkg::CLFP_IDLE;
      end
      clfp_pkg::CLFP_PUSH: begin
        if (xfer_end) state_nxt = clfp_pkg::CLFP_IDLE;
      end
      clfp_pkg::CLFP_WTHR: begin
        state_nxt = clfp_pkg::CLFP_IDLE;
      end
      default: begin
        state_nxt = clfp_pkg::CLFP_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) state_r <= clfp_pkg::CLFP_IDLE;
    else state_r <= state_nxt;
  end

  // Miss capture
  always_ff @(posedge MCLK) begin
    if (RST) begin
      first_idx_r <= 2'h0;
      line_addr_r <= 32'h0;
      is_data_r <= 1'b0;
      cb_write_r <= 1'b0;
      await2_r <= 1'b0;
      way_r <= 2'h0;
    end else if (accept_miss) begin
      first_idx_r <= MISS_ADDR[3:2];
      line_addr_r <= MISS_ADDR;
      is_data_r <= MISS_IS_DATA;
      cb_write_r <= MISS_IS_WRITE_CB;
      await2_r <= MISS_AWAIT2;
      way_r <= pick_way;
    end
  end

  // Beat count and first-cycle qualifiers
  always_ff @(posedge MCLK) begin
    if (RST || accept_miss || start_push) begin
      beat_r <= 2'h0;
      inhibit_r <= 1'b0;
      burst_off_r <= 1'b0;
    end else if (ack_seen) begin
      beat_r <= beat_next;
      if (first_beat) begin
        inhibit_r <= FILL_CACHE_INHIBIT;
        burst_off_r <= BURST_INHIBIT;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus side
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      req_r <= 1'b0;
      write_r <= 1'b0;
      lock_r <= 1'b0;
      addr_r <= 32'h0;
      wdata_r <= 32'h0;
      size_r <= clfp_pkg::SIZE_LONG;
      tm_r <= clfp_pkg::TM_DATA;
    end else if (accept_miss) begin
      req_r <= 1'b1;
      write_r <= 1'b0;
      lock_r <= 1'b0;
      addr_r <= {MISS_ADDR[31:2], 2'h0};
      size_r <= clfp_pkg::SIZE_LINE;
      tm_r <= clfp_pkg::TM_DATA;
    end else if (start_push) begin
      req_r <= 1'b1;
      write_r <= 1'b1;
      lock_r <= accept_push && PUSH_LOCKED;
      addr_r <= {src_addr[31:4], src_idx, 2'h0};
      wdata_r <= word_of(src_line, src_idx);
      size_r <= many_dirty(src_dirty) ? clfp_pkg::SIZE_LINE : clfp_pkg::SIZE_LONG;
      tm_r <= clfp_pkg::TM_PUSH;
    end else if (xfer_end) begin
      req_r <= 1'b0;
      write_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      if (gap_now) begin
        req_r <= 1'b0;
        size_r <= clfp_pkg::SIZE_LONG;
        addr_r <= gap_addr;
      end else if (in_xfer && !req_r) begin
        req_r <= 1'b1;
      end
      if (ack_seen && in_push) wdata_r <= word_of(pb_line_r, beat_next);
    end
  end

  // ---------------------------------------------------------------
  // Push buffer
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pb_valid_r <= 1'b0;
    end else if ((accept_miss || accept_push) && (|VICTIM_DIRTY)) begin
      pb_valid_r <= 1'b1;
      pb_line_r <= VICTIM_LINE;
      pb_addr_r <= VICTIM_ADDR;
      pb_dirty_r <= VICTIM_DIRTY;
      push_line_r <= many_dirty(VICTIM_DIRTY);
    end else if (restore_r || (in_push && xfer_end)) begin
      pb_valid_r <= 1'b0;
    end
  end

  // Fill outcome, pulsed while in DONE; victim invalidate pulsed in the first FILL cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      line_write_r <= 1'b0;
      restore_r <= 1'b0;
      wthr_r <= 1'b0;
      inval_r <= 1'b0;
    end else begin
      line_write_r <= fill_last && !inhibit_r;
      restore_r <= pb_valid_r && in_fill && (fault_now || (fill_last && inhibit_r));
      wthr_r <= fill_last && inhibit_r && cb_write_r;
      inval_r <= accept_miss && SET_VALID[pick_way];
    end
  end

  // Exceptions
  always_ff @(posedge MCLK) begin
    if (RST) begin
      berr_now_r <= 1'b0;
      berr_pend_r <= 1'b0;
    end else begin
      berr_now_r <= fault_now && (in_push || (is_data_r && (first_beat || await_hit)));
      if (in_fill && fault_now && !is_data_r && first_beat) berr_pend_r <= 1'b1;
      else if (accept_miss) berr_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Line buffer and forwarding
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST || accept_miss) begin
      lbuf_v_r <= 4'h0;
    end else if (in_fill && fault_now) begin
      lbuf_v_r <= 4'h0;
    end else if (fwd_push) begin
      lbuf_v_r[word_idx] <= 1'b1;
      lbuf_r[{word_idx, 5'h00} +: clfp_pkg::WORD_W] <= BUS_RDATA;
    end else if (in_done && inhibit_r) begin
      lbuf_v_r <= 4'h0;
    end
  end

  clfp_fifo #(
    .WIDTH(clfp_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fwd (
    .clk(MCLK),
    .rst(RST),
    .in_valid(fwd_push),
    .in_ready(fifo_in_ready),
    .in_data(BUS_RDATA),
    .out_valid(FWD_VALID),
    .out_ready(FWD_READY),
    .out_data(FWD_DATA)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign MISS_READY = idle;
  assign FILL_WAY = way_r;
  assign FILL_WAY_INDEX = way_r;
  assign VICTIM_INVALIDATE = inval_r;
  assign VICTIM_RESTORE = restore_r;
  assign LINE_WRITE = line_write_r;
  assign LINE_BUF = lbuf_r;
  assign LINE_BUF_VALID = lbuf_v_r;
  assign SNOOP_PUSH_VALID = pb_valid_r;
  assign WRITE_THROUGH = in_wthr;
  assign BERR_NOW = berr_now_r;
  assign BERR_PENDING = berr_pend_r;
  assign BUS_REQ = req_r;
  assign BUS_ADDR = addr_r;
  assign TRANSFER_SIZE_CODE = size_r;
  assign TRANSFER_MODIFIER = tm_r;
  assign BUS_WRITE = write_r;
  assign BUS_LOCK = lock_r;
  assign BUS_WDATA = wdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_pseudo_ack;
    gap_now;
  endsequence

  sequence s_gap_then_req;
    !BUS_REQ ##1 BUS_REQ;
  endsequence

  a_pseudo_gap: assert property (@(posedge MCLK) disable iff (RST)
    s_pseudo_ack |=> s_gap_then_req)
    else $error("no single idle cycle between long-word cycles");

  a_fill_line_size: assert property (@(posedge MCLK) disable iff (RST)
    accept_miss |=> BUS_REQ && TRANSFER_SIZE_CODE == clfp_pkg::SIZE_LINE)
    else $error("line read not started with line size");

  a_retry_holds: assert property (@(posedge MCLK) disable iff (RST)
    retry_now |=> BUS_REQ && beat_r == $past(beat_r))
    else $error("retry changed beat or dropped request");

  a_push_marked: assert property (@(posedge MCLK) disable iff (RST)
    in_push && BUS_REQ |-> TRANSFER_MODIFIER == clfp_pkg::TM_PUSH && BUS_WRITE)
    else $error("push cycle without push modifier");

  a_fault_clears: assert property (@(posedge MCLK) disable iff (RST)
    in_fill && fault_now |=> LINE_BUF_VALID == 4'h0)
    else $error("line buffer still valid after fill fault");

  a_burst_addr_held: assert property (@(posedge MCLK) disable iff (RST)
    in_fill && ack_seen && !pseudo_mode && !xfer_end |=> $stable(BUS_ADDR))
    else $error("burst address moved");

  a_fwd_room: assert property (@(posedge MCLK) disable iff (RST)
    fwd_push |-> fifo_in_ready)
    else $error("forward queue full on arriving word");
endmodule : clfp_ctrl
`default_nettype wire

// ===== rtl/clfp_pkg.sv
/*
  Constants, types and encodings shared by the line fill and push controller.
  Assumes a 32-bit bus of long words, four long words to a line, four ways to a set.

  //Contract
  //- Place a new line in the first invalid way; else pick victim pseudo-randomly.
  //- Instruction and data caches each keep their own two-bit replacement counter.
  //- Instruction counter advances once per half-line accessed.
  //- Data counter: per read half-line, copyback write line, writethrough bus transfer.
  //- All ways valid on miss: replace counter-selected way, then advance counter.
  //- Cachable read miss or copyback write miss starts line read with size and way.
  //- Burst inhibit on first word: end line access, then three long-word reads.
  //- First ack without burst inhibit: keep address, latch four words by ack.
  //- First cycle fetches the requested entry (lower part if spanning two).
  //- Inhibit on first cycle blocks cache load, transfer runs out, buffer dropped.
  //- Bus error on first cycle aborts; data immediate, prefetch pending exception.
  //- Bus error later aborts, invalidates buffer; exception only if word awaited.
  //- Ack plus error ack on first fill cycle retries; later it is bus error.
  //- Dirty victim goes to push buffer; restored if fill inhibited or errors.
  //- Inhibited fill after copyback write miss makes the write go through.
  //- Push on replacement, push instruction, or noncachable hit; locked marker kept.
  //- Push buffer snoop-visible only; written after successful fill, then freed.
  //- One dirty entry: single long-word push, modifier 000, retry allowed.
  //- Two or more dirty: burst push, three writes under inhibit, first retry only.
*/

package clfp_pkg;
  localparam int WORD_W = 32;
  localparam int LINE_WORDS = 4;
  localparam int LINE_W = 128;
  localparam int WAYS = 4;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_LINE = 2'h3;
  localparam logic [2:0] TM_PUSH = 3'h0;
  localparam logic [2:0] TM_DATA = 3'h1;
  localparam logic [1:0] IDX_LAST = 2'h3;

  typedef enum logic [2:0] {
    CLFP_IDLE = 3'b000,
    CLFP_FILL = 3'b001,
    CLFP_PUSH = 3'b010,
    CLFP_DONE = 3'b011,
    CLFP_WTHR = 3'b100
  } clfp_state_t;
endpackage : clfp_pkg

// ===== rtl/clfp_fifo.sv
/*
  Parameterised word FIFO with valid/ready on both sides.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module clfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];

  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : clfp_fifo
`default_nettype wire

// ===== rtl/clfp_victim.sv
/*
  Victim way choice and replacement counter for one cache.
  Assumes the owner pulses the advance and use strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module clfp_victim (
  input wire logic clk,
  input wire logic rst,
  // Set state
  input wire logic [3:0] way_valid,
  // Counter steps
  input wire logic adv,
  input wire logic take,
  // Result
  output logic [1:0] way,
  output logic [1:0] cnt
);
  logic [1:0] cnt_r;
  logic all_valid;
  logic [1:0] first_inv;

  function automatic logic [1:0] first_zero(input logic [3:0] v);
    first_zero = !v[0] ? 2'h0 : !v[1] ? 2'h1 : !v[2] ? 2'h2 : 2'h3;
  endfunction : first_zero

  assign all_valid = &way_valid;
  assign first_inv = first_zero(way_valid);
  assign way = all_valid ? cnt_r : first_inv;
  assign cnt = cnt_r;

  always_ff @(posedge clk) begin
    if (rst) cnt_r <= clfp_pkg::CNT_RESET;
    else if (adv || (take && all_valid)) cnt_r <= cnt_r + 2'h1;
  end

  a_victim_counter: assert property (@(posedge clk) disable iff (rst)
    take && all_valid && !adv |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("counter did not advance after victim use");
endmodule : clfp_victim
`default_nettype wire

// ===== tb/clfp_slave.sv
/*
  Processor bus slave model that answers long-word and line cycles.
  Assumes the master holds its request until it samples the acks it needs.
*/
`timescale 1ns/1ps
`default_nettype none

module clfp_slave (
  // Clock
  input wire logic clk,
  // Request
  input wire logic req,
  input wire logic [31:0] addr,
  // Answer
  output logic ack,
  output logic [31:0] rdata
);
  logic [1:0] beat_r;
  initial begin
    ack = 1'b0;
    beat_r = 2'h0;
    rdata = 32'h0;
  end
  // One wait cycle before each ack; a released bus shows the inverse
  always @(posedge clk) begin
    if (req && !ack) begin
      ack <= 1'b1;
      rdata <= {addr[31:4], addr[3:2] + beat_r, 2'h0};
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
    end
    if (ack) begin
      beat_r <= beat_r + 2'h1;
    end
    if (!req) begin
      beat_r <= 2'h0;
    end
  end
endmodule : clfp_slave
`default_nettype wire

// ===== tb/cache_line_fill_push_control_test.sv
/*
  Testbench for the line fill and push controller.
  Assumes the slave model beside it and a miss handshake by MISS_READY.
*/
`timescale 1ns/1ps
`default_nettype none

module cache_line_fill_push_control_test;
  logic MCLK = 1'b0, RST = 1'b1, z = 1'b0, MISS_REQ = 1'b0, PUSH_REQ = 1'b0;
  logic [3:0] SET_VALID = 4'hf, VICTIM_DIRTY = 4'h0;
  logic [31:0] MISS_ADDR = 32'h0, RD;
  logic MISS_READY, FWD_VALID, BUS_REQ, BUS_WRITE, TA;
  logic [1:0] SZ, WI;
  logic [2:0] TM;
  logic [31:0] FWD_DATA, BUS_ADDR;
  int n_mismatch = 0, checks_done = 0, k, n;
  always #2.5 MCLK = ~MCLK;
  clfp_ctrl dut (.MCLK(MCLK), .RST(RST), .IC_HALF_ACCESS(z), .DC_READ_HALF(z),
    .DC_CB_WRITE_LINE(z), .DC_WT_TRANSFER(z), .MISS_REQ(MISS_REQ), .MISS_IS_DATA(1'b1),
    .MISS_IS_WRITE_CB(z), .MISS_AWAIT2(z), .MISS_ADDR(MISS_ADDR), .SET_VALID(SET_VALID),
    .VICTIM_DIRTY(VICTIM_DIRTY), .VICTIM_LINE(128'h0), .VICTIM_ADDR(32'h2000),
    .PUSH_REQ(PUSH_REQ), .PUSH_LOCKED(z), .MISS_READY(MISS_READY), .FILL_WAY(),
    .VICTIM_INVALIDATE(), .VICTIM_RESTORE(), .LINE_WRITE(), .LINE_BUF(),
    .LINE_BUF_VALID(), .SNOOP_PUSH_VALID(), .WRITE_THROUGH(), .FWD_VALID(FWD_VALID),
    .FWD_READY(1'b1), .FWD_DATA(FWD_DATA), .BERR_NOW(), .BERR_PENDING(),
    .BUS_REQ(BUS_REQ), .BUS_ADDR(BUS_ADDR), .TRANSFER_SIZE_CODE(SZ),
    .FILL_WAY_INDEX(WI), .TRANSFER_MODIFIER(TM), .BUS_WRITE(BUS_WRITE), .BUS_LOCK(),
    .BUS_WDATA(), .BUS_RDATA(RD), .TRANSFER_ACK(TA), .TRANSFER_ERROR_ACK(z),
    .BURST_INHIBIT(z), .FILL_CACHE_INHIBIT(z));
  clfp_slave slave (.clk(MCLK), .req(BUS_REQ), .addr(BUS_ADDR), .ack(TA), .rdata(RD));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_req();
    for (n = 0; n < 200 && BUS_REQ !== 1'b1; n++) @(posedge MCLK);
    if (n == 200) begin
      n_mismatch++;
      final_report();
    end
  endtask : wait_req

  // A miss: check way and size, then four forwarded words in wrap order
  task automatic fill(input logic [3:0] v, input logic [1:0] way);
    @(posedge MCLK);
    SET_VALID <= v;
    MISS_ADDR <= 32'h1008;
    MISS_REQ <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (MISS_READY !== 1'b1 && n < 200);
    MISS_REQ <= 1'b0;
    if (n == 200) begin
      n_mismatch++;
      final_report();
    end
    wait_req();
    cmp(WI, way);
    cmp(SZ, clfp_pkg::SIZE_LINE);
    k = 0;
    for (n = 0; n < 300 && k < 4; n++) begin
      @(posedge MCLK);
      if (FWD_VALID === 1'b1) begin
        cmp(FWD_DATA, {28'h100, 2'h2 + 2'(k), 2'h0});
        k++;
      end
    end
    cmp(k, 4);
    $display("fill test done");
  endtask : fill

  initial begin
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    fill(4'hf, 2'h0);
    fill(4'h3, 2'h2);
    repeat (20) @(posedge MCLK);
    VICTIM_DIRTY <= 4'h1;
    PUSH_REQ <= 1'b1;
    wait_req();
    PUSH_REQ <= 1'b0;
    cmp(TM, clfp_pkg::TM_PUSH);
    cmp(SZ, clfp_pkg::SIZE_LONG);
    cmp(BUS_WRITE, 1'b1);
    cmp(BUS_ADDR, 32'h2000);
    $display("push test done");
    final_report();
  end
endmodule : cache_line_fill_push_control_test
`default_nettype wire
